// ### src/rcb_pkg.sv
// shared constants, types and field helpers of the reference clock buffer
package rcb_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 32;
	localparam logic [15:0] CTRL_ADDR        = 16'h0000;
	localparam logic [15:0] STATUS_ADDR      = 16'h0004;
	localparam logic [15:0] PAIR0_CFG_ADDR   = 16'h0DBF;
	localparam logic [15:0] PAIR1_CFG_ADDR   = 16'h0FBF;

	// ****************************************************************
	// field layout and reset values
	// ****************************************************************
	localparam int          DRIVE_EN_BIT     = 17;
	localparam int          SEL_LSB          = 13;
	localparam int          SEL_W            = 2;
	localparam int          CTRL_MODE_BIT    = 0;
	localparam int          CTRL_AUX_LSB     = 1;
	localparam int          NUM_CH           = 4;
	localparam int          PIN_W            = 10;
	localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
	localparam logic        MODE_RESET       = 1'b0;
	localparam logic [1:0]  AUX_RESET        = 2'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		AUX_PASS = 2'h0,
		AUX_DIV2 = 2'h1,
		AUX_LOW  = 2'h2,
		AUX_RSVD = 2'h3
	} rcb_aux_e;

	typedef enum logic {
		MODE_INPUT,
		MODE_OUTPUT
	} rcb_mode_e;

	// source select field of a pair configuration word
	function automatic logic [1:0] rcb_sel_of(input logic [31:0] word);
		rcb_sel_of = word[SEL_LSB +: SEL_W];
	endfunction : rcb_sel_of

endpackage : rcb_pkg

// ### src/rcb_aux_div.sv
// auxiliary clock output: pass, divide by two or constant low
`timescale 1ns/1ps
module rcb_aux_div (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       clk_level_i,
	input  wire logic       enabled_i,
	input  wire logic [1:0] sel_i,
	output logic            aux_o
);
	logic prev_q;
	logic div_q;
	logic rise;

	assign rise = clk_level_i & ~prev_q;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= clk_level_i;
		end
	end

	// divider held low while powered down
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= 1'b0;
		end else if (!enabled_i) begin
			div_q <= 1'b0;
		end else if (rise) begin
			div_q <= ~div_q;
		end
	end

	// reserved code drives low, the safest answer
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aux_o <= 1'b0;
		end else if (!enabled_i) begin
			aux_o <= 1'b0;
		end else begin
			unique case (rcb_pkg::rcb_aux_e'(sel_i))
				rcb_pkg::AUX_PASS: aux_o <= clk_level_i;
				rcb_pkg::AUX_DIV2: aux_o <= div_q;
				rcb_pkg::AUX_LOW:  aux_o <= 1'b0;
				rcb_pkg::AUX_RSVD: aux_o <= 1'b0;
			endcase
		end
	end

	a_div_toggle: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(enabled_i && rise) |=> (div_q != $past(div_q)))
		else $error("divider did not toggle on rising edge");

	a_div_idle: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		!enabled_i |=> !div_q)
		else $error("divider not held low while powered down");

	a_aux_select: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(enabled_i && sel_i == 2'h0) |=> (aux_o == $past(clk_level_i)))
		else $error("aux pass mode does not follow clock");

	a_aux_low: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(sel_i == 2'h2) |=> !aux_o)
		else $error("aux low mode not low");

endmodule : rcb_aux_div

// ### src/rcb_pad_drive.sv
// one reference pad pair driven from a selected recovered clock
`timescale 1ns/1ps
module rcb_pad_drive (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic [3:0] rec_clk_i,
	input  wire logic [1:0] sel_i,
	input  wire logic       drive_i,
	output logic            pos_o,
	output logic            neg_o,
	output logic            oe_n_o
);
	logic picked;

	assign picked = rec_clk_i[sel_i];

	// pads float (enable high) unless driving
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pos_o  <= 1'b0;
			neg_o  <= 1'b0;
			oe_n_o <= 1'b1;
		end else begin
			pos_o  <= drive_i & picked;
			neg_o  <= drive_i & ~picked;
			oe_n_o <= ~drive_i;
		end
	end

	a_pad_route: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		drive_i |=> (!oe_n_o && pos_o == $past(rec_clk_i[sel_i])
			&& neg_o == !pos_o))
		else $error("pad pair does not carry selected clock");

	a_pad_release: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		!drive_i |=> (oe_n_o && !pos_o && !neg_o))
		else $error("pad pair driven while not enabled");

endmodule : rcb_pad_drive

// ### src/rcb_refclk_buf.sv
// reference clock pad buffering, output routing and auxiliary output
//
// What this block does
// - input mode buffers pad clock toward PLLs
// - output mode drives chosen channel clock out
// - active-low enable; high powers buffer down
// - aux select: pass, half, low, reserved
// - pair 0 source field at bits 14:13
// - pair 1 source field, same encoding
// - per-pair select outputs mirror config fields
// - buffered clock feeds group reference inputs
`timescale 1ns/1ps
module rcb_refclk_buf (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	// register port
	input  wire logic [15:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// pins
	input  wire logic        buffer_enable_n_i,
	input  wire logic        supply_good_flag_i,
	input  wire logic        recovered_clock_ch0_i,
	input  wire logic        recovered_clock_ch1_i,
	input  wire logic        recovered_clock_ch2_i,
	input  wire logic        recovered_clock_ch3_i,
	input  wire logic        ref_pair0_pos_i,
	input  wire logic        ref_pair0_neg_i,
	input  wire logic        ref_pair1_pos_i,
	input  wire logic        ref_pair1_neg_i,
	output logic             ref_pair0_pos_o,
	output logic             ref_pair0_neg_o,
	output logic             ref_pair0_oe_n_o,
	output logic             ref_pair1_pos_o,
	output logic             ref_pair1_neg_o,
	output logic             ref_pair1_oe_n_o,
	// toward the group
	output logic             group_refclk0_o,
	output logic             group_refclk1_o,
	output logic             aux_clock_out_o,
	output logic       [1:0] pair0_select_out_o,
	output logic       [1:0] pair1_select_out_o
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [rcb_pkg::PIN_W-1:0] pin_raw;
	logic [rcb_pkg::PIN_W-1:0] pin_meta_q;
	logic [rcb_pkg::PIN_W-1:0] pin_q;

	assign pin_raw = {buffer_enable_n_i, supply_good_flag_i,
		recovered_clock_ch3_i, recovered_clock_ch2_i,
		recovered_clock_ch1_i, recovered_clock_ch0_i,
		ref_pair1_neg_i, ref_pair1_pos_i,
		ref_pair0_neg_i, ref_pair0_pos_i};

	// enable is asynchronous at the pin; two stages tame it
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_meta_q <= '1;
			pin_q      <= '1;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q      <= pin_meta_q;
		end
	end

	logic       enable_n;
	logic       supply_good;
	logic [3:0] rec_clk;
	logic       pad0_pos;
	logic       pad0_neg;
	logic       pad1_pos;
	logic       pad1_neg;

	assign pad0_pos    = pin_q[0];
	assign pad0_neg    = pin_q[1];
	assign pad1_pos    = pin_q[2];
	assign pad1_neg    = pin_q[3];
	assign rec_clk     = pin_q[7:4];
	assign supply_good = pin_q[8];
	assign enable_n    = pin_q[9];

	// ****************************************************************
	// registers
	// ****************************************************************
	logic        mode_q;
	logic [1:0]  aux_sel_q;
	logic [31:0] pair0_cfg_q;
	logic [31:0] pair1_cfg_q;
	logic        wr_ctrl;
	logic        wr_pair0;
	logic        wr_pair1;

	assign wr_ctrl  = wr_i && (addr_i == rcb_pkg::CTRL_ADDR);
	assign wr_pair0 = wr_i && (addr_i == rcb_pkg::PAIR0_CFG_ADDR);
	assign wr_pair1 = wr_i && (addr_i == rcb_pkg::PAIR1_CFG_ADDR);

	// direction is rewritten, with the aux select, on every CTRL write
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_q    <= rcb_pkg::MODE_RESET;
			aux_sel_q <= rcb_pkg::AUX_RESET;
		end else if (wr_ctrl) begin
			mode_q    <= wdata_i[rcb_pkg::CTRL_MODE_BIT];
			aux_sel_q <= wdata_i[rcb_pkg::CTRL_AUX_LSB +: 2];
		end
	end

	// only the drive enable and source select are kept
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pair0_cfg_q <= rcb_pkg::CFG_RESET;
		end else if (wr_pair0) begin
			pair0_cfg_q <= '0;
			pair0_cfg_q[rcb_pkg::DRIVE_EN_BIT] <=
				wdata_i[rcb_pkg::DRIVE_EN_BIT];
			pair0_cfg_q[rcb_pkg::SEL_LSB +: rcb_pkg::SEL_W] <=
				rcb_pkg::rcb_sel_of(wdata_i);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pair1_cfg_q <= rcb_pkg::CFG_RESET;
		end else if (wr_pair1) begin
			pair1_cfg_q <= '0;
			pair1_cfg_q[rcb_pkg::DRIVE_EN_BIT] <=
				wdata_i[rcb_pkg::DRIVE_EN_BIT];
			pair1_cfg_q[rcb_pkg::SEL_LSB +: rcb_pkg::SEL_W] <=
				rcb_pkg::rcb_sel_of(wdata_i);
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	logic [31:0] rdata_d;
	logic [31:0] status_word;

	// supply good is shown so software can gate its consumers
	assign status_word = {28'h0, rec_clk[3:0] == 4'h0, aux_clock_out_o,
		supply_good, ~enable_n};

	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (addr_i)
			rcb_pkg::CTRL_ADDR:
				rdata_d = {29'h0, aux_sel_q, mode_q};
			rcb_pkg::STATUS_ADDR:    rdata_d = status_word;
			rcb_pkg::PAIR0_CFG_ADDR: rdata_d = pair0_cfg_q;
			rcb_pkg::PAIR1_CFG_ADDR: rdata_d = pair1_cfg_q;
			default:                 rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= rdata_d;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// input mode path
	// ****************************************************************
	logic in_mode;
	logic buf0;
	logic buf1;

	assign in_mode = (mode_q == rcb_pkg::MODE_INPUT) && !enable_n;
	assign buf0    = pad0_pos & ~pad0_neg;
	assign buf1    = pad1_pos & ~pad1_neg;

	// powered-down buffer gives a quiet low, never a stale level
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			group_refclk0_o <= 1'b0;
			group_refclk1_o <= 1'b0;
		end else begin
			group_refclk0_o <= in_mode & buf0;
			group_refclk1_o <= in_mode & buf1;
		end
	end

	rcb_aux_div u_aux (
		.mclk_i      (mclk_i),
		.rst_b_i     (rst_b_i),
		.clk_level_i (buf0),
		.enabled_i   (in_mode),
		.sel_i       (aux_sel_q),
		.aux_o       (aux_clock_out_o)
	);

	// ****************************************************************
	// output mode path
	// ****************************************************************
	logic out_mode;
	logic drive0;
	logic drive1;

	assign out_mode = (mode_q == rcb_pkg::MODE_OUTPUT) && !enable_n;
	// pad drive bit is ignored in input mode
	assign drive0 = out_mode && pair0_cfg_q[rcb_pkg::DRIVE_EN_BIT];
	assign drive1 = out_mode && pair1_cfg_q[rcb_pkg::DRIVE_EN_BIT];

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pair0_select_out_o <= 2'h0;
			pair1_select_out_o <= 2'h0;
		end else begin
			pair0_select_out_o <= rcb_pkg::rcb_sel_of(pair0_cfg_q);
			pair1_select_out_o <= rcb_pkg::rcb_sel_of(pair1_cfg_q);
		end
	end

	rcb_pad_drive u_pad0 (
		.mclk_i    (mclk_i),
		.rst_b_i   (rst_b_i),
		.rec_clk_i (rec_clk),
		.sel_i     (rcb_pkg::rcb_sel_of(pair0_cfg_q)),
		.drive_i   (drive0),
		.pos_o     (ref_pair0_pos_o),
		.neg_o     (ref_pair0_neg_o),
		.oe_n_o    (ref_pair0_oe_n_o)
	);

	rcb_pad_drive u_pad1 (
		.mclk_i    (mclk_i),
		.rst_b_i   (rst_b_i),
		.rec_clk_i (rec_clk),
		.sel_i     (rcb_pkg::rcb_sel_of(pair1_cfg_q)),
		.drive_i   (drive1),
		.pos_o     (ref_pair1_pos_o),
		.neg_o     (ref_pair1_neg_o),
		.oe_n_o    (ref_pair1_oe_n_o)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	a_ref_follow: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		in_mode |=> (group_refclk0_o == $past(buf0)
			&& group_refclk1_o == $past(buf1)))
		else $error("group reference does not follow pad clock");

	a_power_down: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		enable_n [*2] |-> (!group_refclk0_o && !group_refclk1_o
			&& !aux_clock_out_o && ref_pair0_oe_n_o && ref_pair1_oe_n_o))
		else $error("outputs active while buffer powered down");

	a_sel_mirror: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		wr_pair0 |=> ##1 (pair0_select_out_o ==
			$past(wdata_i[14:13], 2)))
		else $error("pair 0 select output does not follow field");

	a_sel_pair1: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		wr_pair1 |=> (pair1_cfg_q[14:13] == $past(wdata_i[14:13])))
		else $error("pair 1 select field not stored");

	a_no_drive_in: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mode_q == rcb_pkg::MODE_INPUT) [*2] |->
			(ref_pair0_oe_n_o && ref_pair1_oe_n_o))
		else $error("pads driven in input mode");

	a_read_cfg: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == rcb_pkg::PAIR0_CFG_ADDR) |=>
			(rdata_o[14:13] == $past(pair0_cfg_q[14:13])))
		else $error("pair 0 config read back wrong");

	a_out_quiet: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		out_mode |=> (!group_refclk0_o && !group_refclk1_o))
		else $error("group reference active in output mode");

	a_status_read: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == rcb_pkg::STATUS_ADDR) |=> (rdata_o[1] ==
			$past(supply_good) && rdata_o[0] == !$past(enable_n)))
		else $error("status read does not show supply and enable");

	a_sel_out1: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		wr_pair1 |=> ##1 (pair1_select_out_o ==
			$past(wdata_i[14:13], 2)))
		else $error("pair 1 select output does not follow field");

endmodule : rcb_refclk_buf

// ### bench/rcb_chan_model.sv
// far-side model: channel recovered clocks, pad clocks and supply good
`timescale 1ns/1ps
module rcb_chan_model (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	output logic      [3:0] rec_clk_o,
	output logic      [1:0] pad_clk_o,
	output logic            supply_good_o
);
	int cnt;

	// distinct periods so a wrong channel choice shows up at the pads
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 0;
			rec_clk_o <= 4'h0;
			pad_clk_o <= 2'h0;
			supply_good_o <= 1'b0;
		end else begin
			cnt <= cnt + 1;
			for (int n = 0; n < 4; n++) begin
				if (cnt % (n + 2) == 0) begin
					rec_clk_o[n] <= ~rec_clk_o[n];
				end
			end
			if (cnt % 4 == 0) pad_clk_o[0] <= ~pad_clk_o[0];
			if (cnt % 6 == 0) pad_clk_o[1] <= ~pad_clk_o[1];
			supply_good_o <= (cnt >= 12);
		end
	end
endmodule : rcb_chan_model

// ### bench/tb_rcb_refclk_buf.sv
// self-checking testbench of the reference clock buffer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	n_fail++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
	end end
module tb_rcb_refclk_buf;
	logic        mclk_i  = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [15:0] addr_i  = 16'h0000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic        en_n    = 1'b0;
	logic [31:0] rdata_o, d;
	logic [3:0]  rec;
	logic [1:0]  padc, s0, s1;
	logic        sgood, p0o, n0o, oe0, p1o, n1o, oe1, g0, g1, aux;
	logic        aux_p, g_p;
	logic [2:0]  h_ch [4];
	logic [2:0]  h_p0, h_p1;
	int          mon = 0, msel = 0, mpair = 0, n_aux, n_g, cycles = 0;
	int          n_fail = 0, checked = 0;
	logic        ok_div;
	logic [31:0] cfg_w;
	localparam logic [31:0] M_ALL  = 32'hFFFF_FFFF;
	localparam logic [15:0] A_CTRL = rcb_pkg::CTRL_ADDR;
	localparam logic [15:0] A_STAT = rcb_pkg::STATUS_ADDR;
	localparam logic [15:0] A_P0   = rcb_pkg::PAIR0_CFG_ADDR;
	localparam logic [15:0] A_P1   = rcb_pkg::PAIR1_CFG_ADDR;
	wire         pad0 = oe0 ? padc[0] : p0o;
	wire         neg0 = oe0 ? ~padc[0] : n0o;
	wire         pad1 = oe1 ? padc[1] : p1o;
	wire         neg1 = oe1 ? ~padc[1] : n1o;
	wire         pos_s = mpair ? p1o : p0o;
	wire         neg_s = mpair ? n1o : n0o;
	wire         oe_s  = mpair ? oe1 : oe0;

	always #2.5 mclk_i = ~mclk_i;

	rcb_chan_model far (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .rec_clk_o(rec),
		.pad_clk_o(padc), .supply_good_o(sgood));
	rcb_refclk_buf dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.buffer_enable_n_i(en_n), .supply_good_flag_i(sgood),
		.recovered_clock_ch0_i(rec[0]), .recovered_clock_ch1_i(rec[1]),
		.recovered_clock_ch2_i(rec[2]), .recovered_clock_ch3_i(rec[3]),
		.ref_pair0_pos_i(pad0), .ref_pair0_neg_i(neg0),
		.ref_pair1_pos_i(pad1), .ref_pair1_neg_i(neg1),
		.ref_pair0_pos_o(p0o), .ref_pair0_neg_o(n0o), .ref_pair0_oe_n_o(oe0),
		.ref_pair1_pos_o(p1o), .ref_pair1_neg_o(n1o), .ref_pair1_oe_n_o(oe1),
		.group_refclk0_o(g0), .group_refclk1_o(g1), .aux_clock_out_o(aux),
		.pair0_select_out_o(s0), .pair1_select_out_o(s1));

	// ****************************************************************
	// history of pin levels: outputs lag them by three edges
	// ****************************************************************
	always @(posedge mclk_i) begin
		h_p0 <= {h_p0[1:0], pad0 & ~neg0};
		h_p1 <= {h_p1[1:0], pad1 & ~neg1};
		for (int n = 0; n < 4; n++) h_ch[n] <= {h_ch[n][1:0], rec[n]};
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	always @(negedge mclk_i) begin
		case (mon)
			1: begin
				`CHK("group0", h_p0[2], g0)
				`CHK("group1", h_p1[2], g1)
				`CHK("aux pass", h_p0[2], aux)
				`CHK("pads idle", 1'b1, oe0 & oe1)
			end
			2: `CHK("powered down", 1'b0, g0 | g1 | aux)
			3: begin
				`CHK("pad pos", h_ch[msel][2], pos_s)
				`CHK("pad neg", ~h_ch[msel][2], neg_s)
				`CHK("pad oe_n", 1'b0, oe_s)
				`CHK("group out", 1'b0, g0)
			end
			4: `CHK("aux low", 1'b0, aux)
			5: begin
				n_aux += (aux && !aux_p);
				n_g += (g0 && !g_p);
			end
			default: ;
		endcase
		aux_p = aux;
		g_p = g0;
	end

	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rchk(input string nm, input logic [15:0] a,
		input logic [31:0] m, input logic [31:0] ex);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		`CHK(nm, ex, d & m)
	endtask : rchk

	task automatic run(input int m, input int n);
		repeat (4) @(posedge mclk_i);
		mon = m;
		repeat (n) @(posedge mclk_i);
		mon = 0;
	endtask : run

	task automatic do_reset;
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
	endtask : do_reset

	task automatic results;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	initial begin
		do_reset();
		rchk("ctrl reset", A_CTRL, M_ALL, 32'h0);
		rchk("pair0 reset", A_P0, M_ALL, 32'h0);
		`CHK("oe_n reset", 1'b1, oe0 & oe1)
		// consumers wait for supply good before trusting the clock
		repeat (16) @(posedge mclk_i);
		rchk("status", A_STAT, 32'h3, 32'h3);
		wr(A_P0, M_ALL);
		rchk("pair0 mask", A_P0, M_ALL, 32'h0002_6000);
		wr(A_P1, 32'h0000_4000);
		rchk("pair1", A_P1, M_ALL, 32'h0000_4000);
		`CHK("sel out0", 2'h3, s0)
		`CHK("sel out1", 2'h2, s1)
		wr(16'h0010, M_ALL);
		rchk("unmapped", 16'h0010, M_ALL, 32'h0);
		wr(A_P0, 32'h0);
		wr(A_P1, 32'h0);
		wr(A_CTRL, 32'h0);
		run(1, 40);
		wr(A_CTRL, 32'h2);
		n_aux = 0;
		n_g = 0;
		run(5, 96);
		ok_div = n_g > 8 && n_aux * 2 >= n_g - 2 && n_aux * 2 <= n_g + 2;
		`CHK("div2", 1'b1, ok_div)
		wr(A_CTRL, 32'h4);
		run(4, 40);
		// reserved code chosen to read as low
		wr(A_CTRL, 32'h6);
		run(4, 40);
		wr(A_CTRL, 32'h2);
		en_n <= 1'b1;
		run(2, 40);
		rchk("status down", A_STAT, 32'h1, 32'h0);
		// direction changes on any CTRL write; here it is set to output after a fresh reset
		do_reset();
		en_n <= 1'b0;
		wr(A_CTRL, 32'h1);
		repeat (4) @(posedge mclk_i);
		`CHK("no drive", 1'b1, oe0 & oe1)
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 4; s++) begin
				mpair = p;
				msel = s;
				cfg_w = 32'h0002_0000 | (32'(s) << 13);
				wr(p ? A_P1 : A_P0, cfg_w);
				run(3, 30);
				`CHK("sel out", 2'(s), p ? s1 : s0)
			end
		end
		results();
	end
endmodule : tb_rcb_refclk_buf
